// ==== hdl/clk_synth_pkg.sv ====
// Constants, field layout and carrier types for the clock synthesizer
// control bank. Assumes byte-wide registers reached over SMBus only.
package clk_synth_pkg;
    // Bus addresses, read/write flag in bit 0
    localparam logic [7:0] WR_ADDR = 8'hD2;
    localparam logic [7:0] RD_ADDR = 8'hD3;
    // Register indices
    localparam logic [7:0] IDX_DIFF_EN = 8'h00;
    localparam logic [7:0] IDX_PROC_REF = 8'h01;
    localparam logic [7:0] IDX_PCI_USB = 8'h02;
    localparam logic [7:0] IDX_SWING = 8'h03;
    localparam logic [7:0] IDX_SPREAD = 8'h04;
    localparam logic [7:0] IDX_NS_FREQ = 8'h05;
    localparam logic [7:0] IDX_TEST_FREQ = 8'h06;
    localparam logic [7:0] IDX_VEND_REV = 8'h07;
    localparam logic [7:0] IDX_READBACK = 8'h08;
    localparam logic [7:0] IDX_PART = 8'h09;
    // Writable bits per register, the rest read as zero
    localparam logic [7:0] MASK_DIFF_EN = 8'hFF;
    localparam logic [7:0] MASK_PROC_REF = 8'h9F;
    localparam logic [7:0] MASK_PCI_USB = 8'h3F;
    localparam logic [7:0] MASK_SWING = 8'hFF;
    localparam logic [7:0] MASK_SPREAD = 8'h03;
    localparam logic [7:0] MASK_NS_FREQ = 8'h0F;
    localparam logic [7:0] MASK_TEST_FREQ = 8'hC7;
    // Reset values
    localparam logic [7:0] RST_DIFF_EN = 8'hFF;
    localparam logic [7:0] RST_PROC_REF = 8'h9E;
    localparam logic [7:0] RST_PCI_USB = 8'h3F;
    localparam logic [7:0] RST_SWING = 8'h55;
    localparam logic [7:0] RST_SPREAD = 8'h03;
    localparam logic [7:0] RST_NS_FREQ = 8'h07;
    localparam logic [7:0] RST_TEST_FREQ = 8'h03;
    localparam logic [7:0] RST_READBACK = 8'h0A;
    // Field positions
    localparam int REF_EN_BIT = 7;
    localparam int CPU_EN_MSB = 4;
    localparam int CPU_EN_LSB = 1;
    localparam int SPREAD_EN_BIT = 0;
    localparam int PCI_USB_MSB = 5;
    localparam int DEPTH_MSB = 1;
    localparam int NS_FREQ_MSB = 3;
    localparam int MAIN_FREQ_MSB = 2;
    localparam int TEST_EN_BIT = 6;
    localparam int TEST_TYPE_BIT = 7;
    // Bit phases of one byte on the link
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // Writable register image
    typedef struct packed {
        logic [7:0] diff_en;
        logic [7:0] proc_ref_en;
        logic [7:0] pci_usb_en;
        logic [7:0] swing;
        logic [7:0] spread;
        logic [7:0] ns_freq;
        logic [7:0] test_freq;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{RST_DIFF_EN, RST_PROC_REF, RST_PCI_USB,
        RST_SWING, RST_SPREAD, RST_NS_FREQ, RST_TEST_FREQ};

    // Controls handed to the synthesizer core and output drivers
    typedef struct packed {
        logic [11:0] diff_run;
        logic [6:0] se_run;
        logic ref_oe_n;
        logic outputs_hiz;
        logic ref_div_mode;
        logic spread_on;
        logic [1:0] spread_depth;
        logic [7:0] swing;
        logic [3:0] ns_freq;
        logic [2:0] main_freq;
        logic plls_stopped;
    } ctrl_t;

    typedef enum {LK_WAIT, LK_IGNORE, LK_ADDR, LK_INDEX, LK_COUNT,
        LK_WDATA, LK_RDATA} link_state_t;
endpackage

// ==== hdl/three_stage_sync.sv ====
// Three flip-flop synchroniser for one level or toggle.
// Assumes the input is slow against clk; output moves when stages agree.
`timescale 1ns/1ps
`default_nettype none
module three_stage_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_reg; // Only read by s2_reg
    logic s2_reg;
    logic s3_reg;

    // Shift chain, accept value once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q <= s3_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/clock_synth_smbus_control_bank.sv ====
// SMBus register bank of a multi-output clock synthesizer.
// Assumes smb_clk is the bus clock from the host and clk a free 50 MHz.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Ack write address, index and count
// - Store count bytes upward, ack each
// - Ack read address after repeated start
// - Return count, then registers from index
// - Register 8 sets read-back length
// - Register 0 enables eight differential pairs
// - Register 1 enables reference and processors
// - Register 1 bit 0 enables spread
// - Register 2 enables PCI and 48M
// - Register 3 holds four swing codes
// - Register 5 non-spreading frequency code
// - Register 6 processor frequency code
// - Register 6 test enable and type
// - Register 7 read-only revision and vendor
// - Register 9 read-only part identifier
// - Strap outputs float until first power-good
// - Power-down forces all outputs low except in test float mode
module clock_synth_smbus_control_bank #(
    parameter logic [3:0] REVISION_ID = 4'h3, // Arbitrary value
    parameter logic [3:0] VENDOR_ID = 4'hA, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h5C // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe_n,
    input wire logic power_good_powerdown_in,
    output var clk_synth_pkg::ctrl_t ctrl
);
    import clk_synth_pkg::*;

    // Link domain state
    logic link_rst_n; // Reset carried into the bus clock domain
    link_state_t state_reg; // Frame phase
    logic [3:0] bit_cnt_reg; // Bit phase inside a byte
    logic [7:0] shift_reg; // Received bits
    logic [7:0] index_reg; // Current register index
    logic [7:0] remain_reg; // Write bytes still expected
    logic [7:0] tx_reg; // Byte being returned
    logic [7:0] len_reg; // Read-back length register
    logic sda_rise_reg; // Data line at last rising edge
    logic tx_started_reg; // Count byte already sent
    logic wr_tgl_reg; // Flips on each stored write
    logic start_seen; // Start or repeated start
    logic [7:0] rd_byte; // Register contents at the read index
    cfg_t cfg_link_reg; // Register image written by the bus

    // Clock domain state
    logic pwr_pin_q; // Synchronised power pin
    logic wr_tgl_q; // Synchronised write toggle
    logic seen_tgl_reg; // Last toggle value taken
    logic pg_seen_reg; // Power-good applied at least once
    logic running; // Outputs may run
    logic hiz_mode; // Test mode floating outputs
    cfg_t cfg_reg; // Image applied to the core

    // Merge one written byte into the image, masking reserved bits
    function automatic cfg_t put_byte(cfg_t c, logic [7:0] idx,
                                      logic [7:0] d);
        put_byte = c;
        case (idx)
            IDX_DIFF_EN: put_byte.diff_en = d & MASK_DIFF_EN;
            IDX_PROC_REF: put_byte.proc_ref_en = d & MASK_PROC_REF;
            IDX_PCI_USB: put_byte.pci_usb_en = d & MASK_PCI_USB;
            IDX_SWING: put_byte.swing = d & MASK_SWING;
            IDX_SPREAD: put_byte.spread = d & MASK_SPREAD;
            IDX_NS_FREQ: put_byte.ns_freq = d & MASK_NS_FREQ;
            IDX_TEST_FREQ: put_byte.test_freq = d & MASK_TEST_FREQ;
            default: ; // Read-only or unmapped index
        endcase
    endfunction

    // Register contents seen by a bus read
    function automatic logic [7:0] get_byte(cfg_t c, logic [7:0] len,
                                            logic [7:0] idx);
        case (idx)
            IDX_DIFF_EN: get_byte = c.diff_en;
            IDX_PROC_REF: get_byte = c.proc_ref_en;
            IDX_PCI_USB: get_byte = c.pci_usb_en;
            IDX_SWING: get_byte = c.swing;
            IDX_SPREAD: get_byte = c.spread;
            IDX_NS_FREQ: get_byte = c.ns_freq;
            IDX_TEST_FREQ: get_byte = c.test_freq;
            IDX_VEND_REV: get_byte = {REVISION_ID, VENDOR_ID};
            IDX_READBACK: get_byte = len;
            IDX_PART: get_byte = PART_ID;
            default: get_byte = 8'h00;
        endcase
    endfunction

    // Reset into the bus clock domain; needs bus clock edges to take
    three_stage_sync #(.RESET_VAL(1'b0)) u_link_rst (
        .clk(smb_clk),
        .rst_n(1'b1),
        .d(rst_n),
        .q(link_rst_n)
    );

    // Start when data falls with clock high; after a frame end the
    // bus sat idle, so a low line at the falling clock is a start
    assign start_seen = !smb_data_in && (sda_rise_reg ||
                                         state_reg == LK_WAIT);

    // Byte a read returns next, one lookup shared by data and first bit
    assign rd_byte = get_byte(cfg_link_reg, len_reg, index_reg);

    // Sample the data line on each rising bus clock
    always_ff @(posedge smb_clk) begin
        if (!link_rst_n) begin
            sda_rise_reg <= 1'b0;
            shift_reg <= 8'h00;
        end else begin
            sda_rise_reg <= smb_data_in;
            shift_reg <= {shift_reg[6:0], smb_data_in};
        end
    end

    // Open-drain output only ever pulls low
    always_ff @(posedge smb_clk) begin
        smb_data_out <= 1'b0;
    end

    // Frame engine, changes the data line while the bus clock is low
    always_ff @(negedge smb_clk) begin
        if (!link_rst_n) begin
            state_reg <= LK_WAIT;
            bit_cnt_reg <= 4'h0;
            smb_data_oe_n <= 1'b1;
            index_reg <= 8'h00;
            remain_reg <= 8'h00;
            tx_reg <= 8'h00;
            tx_started_reg <= 1'b0;
            wr_tgl_reg <= 1'b0;
            cfg_link_reg <= CFG_RESET;
            len_reg <= RST_READBACK;
        end else if (start_seen) begin
            // New frame, release the line
            state_reg <= LK_ADDR;
            bit_cnt_reg <= 4'h0;
            smb_data_oe_n <= 1'b1;
        end else if (state_reg != LK_WAIT && state_reg != LK_IGNORE) begin
            if (bit_cnt_reg != BIT_ACK) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == BIT_LAST) begin
                    // Whole byte in; decide on the acknowledge
                    smb_data_oe_n <= 1'b1;
                    unique case (state_reg)
                        LK_ADDR: begin
                            if (shift_reg == WR_ADDR) begin
                                smb_data_oe_n <= 1'b0;
                                state_reg <= LK_INDEX;
                            end else if (shift_reg == RD_ADDR) begin
                                smb_data_oe_n <= 1'b0;
                                state_reg <= LK_RDATA;
                                tx_started_reg <= 1'b0;
                            end else begin
                                state_reg <= LK_IGNORE;
                            end
                        end
                        LK_INDEX: begin
                            index_reg <= shift_reg;
                            smb_data_oe_n <= 1'b0;
                            state_reg <= LK_COUNT;
                        end
                        LK_COUNT: begin
                            remain_reg <= shift_reg;
                            smb_data_oe_n <= 1'b0;
                            state_reg <= LK_WDATA;
                        end
                        LK_WDATA: begin
                            if (remain_reg != 8'h00) begin
                                // Store and move upward
                                smb_data_oe_n <= 1'b0;
                                remain_reg <= remain_reg - 8'h01;
                                index_reg <= index_reg + 8'h01;
                                wr_tgl_reg <= !wr_tgl_reg;
                                cfg_link_reg <= put_byte(cfg_link_reg,
                                    index_reg, shift_reg);
                                if (index_reg == IDX_READBACK) begin
                                    len_reg <= shift_reg;
                                end
                            end
                        end
                        LK_RDATA: ; // Host answers this byte
                        default: ;
                    endcase
                end else if (state_reg == LK_RDATA) begin
                    // Next bit of the returned byte, released for a one
                    smb_data_oe_n <= tx_reg[3'd6 - bit_cnt_reg[2:0]];
                end
            end else begin
                // Acknowledge bit over
                bit_cnt_reg <= 4'h0;
                smb_data_oe_n <= 1'b1;
                if (state_reg == LK_RDATA) begin
                    if (!tx_started_reg) begin
                        // Count goes first
                        tx_reg <= len_reg;
                        smb_data_oe_n <= len_reg[7];
                        tx_started_reg <= 1'b1;
                    end else if (sda_rise_reg) begin
                        state_reg <= LK_WAIT;
                    end else begin
                        // Host acked; return next register upward
                        tx_reg <= rd_byte;
                        smb_data_oe_n <= rd_byte[7];
                        index_reg <= index_reg + 8'h01;
                    end
                end else if (state_reg == LK_WDATA &&
                             remain_reg == 8'h00) begin
                    state_reg <= LK_WAIT;
                end
            end
        end
    end

    // Power pin into the core clock domain
    three_stage_sync #(.RESET_VAL(1'b1)) u_pwr_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(power_good_powerdown_in),
        .q(pwr_pin_q)
    );

    // Write toggle into the core clock domain
    three_stage_sync #(.RESET_VAL(1'b0)) u_wr_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(wr_tgl_reg),
        .q(wr_tgl_q)
    );

    // Take the bus image once a write toggle arrives; image is stable
    // for a whole byte time after each toggle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_tgl_reg <= 1'b0;
            cfg_reg <= CFG_RESET;
        end else if (wr_tgl_q != seen_tgl_reg) begin
            seen_tgl_reg <= wr_tgl_q;
            cfg_reg <= cfg_link_reg;
        end
    end

    // Remember the first power-good, pin low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pg_seen_reg <= 1'b0;
        end else if (!pwr_pin_q) begin
            pg_seen_reg <= 1'b1;
        end
    end

    assign running = pg_seen_reg && !pwr_pin_q;
    assign hiz_mode = cfg_reg.test_freq[TEST_EN_BIT] &&
                      !cfg_reg.test_freq[TEST_TYPE_BIT];

    // Output controls; run enables and spread forced low, PLLs stopped, whenever not running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= '0;
            ctrl.ref_oe_n <= 1'b1;
            ctrl.plls_stopped <= 1'b1;
        end else begin
            ctrl.diff_run <= running ? {cfg_reg.proc_ref_en[CPU_EN_MSB:
                CPU_EN_LSB], cfg_reg.diff_en} : 12'h000;
            ctrl.se_run <= running ? {cfg_reg.proc_ref_en[REF_EN_BIT],
                cfg_reg.pci_usb_en[PCI_USB_MSB:0]} : 7'h00;
            ctrl.ref_oe_n <= !pg_seen_reg || hiz_mode;
            ctrl.outputs_hiz <= hiz_mode;
            ctrl.ref_div_mode <= cfg_reg.test_freq[TEST_EN_BIT] &&
                cfg_reg.test_freq[TEST_TYPE_BIT];
            ctrl.spread_on <= running &&
                cfg_reg.proc_ref_en[SPREAD_EN_BIT];
            ctrl.spread_depth <= cfg_reg.spread[DEPTH_MSB:0];
            ctrl.swing <= cfg_reg.swing;
            ctrl.ns_freq <= cfg_reg.ns_freq[NS_FREQ_MSB:0];
            ctrl.main_freq <= cfg_reg.test_freq[MAIN_FREQ_MSB:0];
            ctrl.plls_stopped <= !running;
        end
    end

    // Checks on the link
    property p_ack_wr_addr;
        @(negedge smb_clk) disable iff (!link_rst_n)
        (state_reg == LK_ADDR && bit_cnt_reg == BIT_LAST &&
         shift_reg == WR_ADDR && !start_seen)
        |=> (!smb_data_oe_n && state_reg == LK_INDEX);
    endproperty
    a_ack_wr_addr: assert property (p_ack_wr_addr)
        else $error("write address not acknowledged");

    property p_wr_store;
        @(negedge smb_clk) disable iff (!link_rst_n)
        (state_reg == LK_WDATA && bit_cnt_reg == BIT_LAST &&
         remain_reg != 8'h00 && !start_seen)
        |=> (!smb_data_oe_n && index_reg == $past(index_reg) + 8'h01 &&
             wr_tgl_reg != $past(wr_tgl_reg));
    endproperty
    a_wr_store: assert property (p_wr_store)
        else $error("write byte not stored and acknowledged");

    property p_ack_rd_addr;
        @(negedge smb_clk) disable iff (!link_rst_n)
        (state_reg == LK_ADDR && bit_cnt_reg == BIT_LAST &&
         shift_reg == RD_ADDR && !start_seen)
        |=> (!smb_data_oe_n && state_reg == LK_RDATA && !tx_started_reg);
    endproperty
    a_ack_rd_addr: assert property (p_ack_rd_addr)
        else $error("read address not acknowledged");

    property p_count_first;
        @(negedge smb_clk) disable iff (!link_rst_n)
        (state_reg == LK_RDATA && bit_cnt_reg == BIT_ACK &&
         !tx_started_reg && !start_seen)
        |=> (tx_reg == $past(len_reg) && smb_data_oe_n == tx_reg[7]);
    endproperty
    a_count_first: assert property (p_count_first)
        else $error("read does not open with the length");

    property p_nack_end;
        @(negedge smb_clk) disable iff (!link_rst_n)
        (state_reg == LK_RDATA && bit_cnt_reg == BIT_ACK &&
         tx_started_reg && sda_rise_reg && !start_seen)
        |=> (state_reg == LK_WAIT && smb_data_oe_n);
    endproperty
    a_nack_end: assert property (p_nack_end)
        else $error("read continued after not-acknowledge");

    property p_reserved_zero;
        // Core reset also masks the edges before the link reset settles
        @(negedge smb_clk) disable iff (!link_rst_n || !rst_n)
        (cfg_link_reg.spread[7:2] == 6'h00 &&
         cfg_link_reg.pci_usb_en[7:6] == 2'h0 &&
         cfg_link_reg.test_freq[5:3] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit took a written value");

    // Checks on the output controls
    property p_power_down;
        @(posedge clk) disable iff (!rst_n)
        (pg_seen_reg && pwr_pin_q) |=> (ctrl.diff_run == 12'h000 &&
            ctrl.se_run == 7'h00 && ctrl.plls_stopped && !ctrl.spread_on);
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("outputs active in power-down");

    property p_strap_float;
        @(posedge clk) disable iff (!rst_n)
        !pg_seen_reg |=> (ctrl.ref_oe_n && ctrl.se_run == 7'h00);
    endproperty
    a_strap_float: assert property (p_strap_float)
        else $error("strap output driven before power-good");

    property p_diff_follow;
        @(posedge clk) disable iff (!rst_n)
        running |=> (ctrl.diff_run[7:0] == $past(cfg_reg.diff_en) &&
            ctrl.se_run[5:0] == $past(cfg_reg.pci_usb_en[5:0]));
    endproperty
    a_diff_follow: assert property (p_diff_follow)
        else $error("output enable does not follow register");

    property p_test_float;
        @(posedge clk) disable iff (!rst_n)
        hiz_mode |=> (ctrl.outputs_hiz && ctrl.ref_oe_n &&
                      !ctrl.ref_div_mode);
    endproperty
    a_test_float: assert property (p_test_float)
        else $error("test float mode not applied");

    c_write: cover property (@(negedge smb_clk) disable iff (!link_rst_n)
        state_reg == LK_WDATA && bit_cnt_reg == BIT_ACK &&
        !smb_data_oe_n);
    c_read: cover property (@(negedge smb_clk) disable iff (!link_rst_n)
        state_reg == LK_RDATA && tx_started_reg && bit_cnt_reg == BIT_ACK);
    c_pdown: cover property (@(posedge clk) disable iff (!rst_n)
        pg_seen_reg && pwr_pin_q);
    c_test: cover property (@(posedge clk) disable iff (!rst_n)
        ctrl.outputs_hiz);
endmodule
`default_nettype wire

// ==== verification/smbus_host_model.sv ====
// SMBus host model: makes the bus clock and pulls the data line low.
// Assumes the bench resolves the wire with a pull-up from all pullers.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    output logic smb_clk,
    output logic host_low,
    input wire logic smb_data
);
    // Clock stands high, data released
    initial begin
        smb_clk = 1'b1;
        host_low = 1'b0;
    end
    // Free clocking around reset only, data released
    task automatic idle(input int n);
        repeat (n) begin
            #24 smb_clk = 1'b0;
            #24 smb_clk = 1'b1;
        end
    endtask
    // One bit: data set while low, wire sampled after the rise
    task automatic bit_out(input logic low, output logic seen);
        host_low = low;
        #12 smb_clk = 1'b1;
        #1 seen = smb_data;
        #23 smb_clk = 1'b0;
        #12;
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        host_low = 1'b0;
        #12 smb_clk = 1'b1;
        #12 host_low = 1'b1;
        #12 smb_clk = 1'b0;
        #12;
    endtask
    // Stop: data rises while clock high, clock then stands
    task automatic stop();
        host_low = 1'b1;
        #12 smb_clk = 1'b1;
        #12 host_low = 1'b0;
        #24;
    endtask
    // Byte to the device, MSB first, then ninth clock for its ack
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(~b[i], s);
        bit_out(1'b0, s);
        ack = ~s;
    endtask
    // Byte from the device; ack unless last, then nack
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b0, s);
            b[i] = s;
        end
        bit_out(~last, s);
    endtask
endmodule
`default_nettype wire

// ==== verification/clock_synth_smbus_control_bank_tb_top.sv ====
// Self-checking bench for the synthesizer control bank.
// Assumes the host model and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    $display("ERROR %s expected %h seen %h", nm, exp, got); n_errors++; end end
module clock_synth_smbus_control_bank_tb_top;
    import clk_synth_pkg::*;
    logic clk, rst_n, pg, smb_clk, host_low, smb_data, oe_n, d_out;
    ctrl_t ctrl; // Controls seen at the core side
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] q[$]; // Bytes to send, or count then bytes expected
    // Open-drain wire with pull-up
    assign smb_data = (host_low || oe_n === 1'b0) ? 1'b0 : 1'b1;
    smbus_host_model host_u (.smb_clk(smb_clk), .host_low(host_low),
        .smb_data(smb_data));
    // Identifier values are arbitrary
    clock_synth_smbus_control_bank #(.REVISION_ID(4'h6), .VENDOR_ID(4'h9),
        .PART_ID(8'hB4)) dut_u (.clk(clk), .rst_n(rst_n),
        .smb_clk(smb_clk), .smb_data_in(smb_data), .smb_data_out(d_out),
        .smb_data_oe_n(oe_n), .power_good_powerdown_in(pg), .ctrl(ctrl));
    // Core clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Verdict and end of run
    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Host byte whose ack is required
    task automatic put(input logic [7:0] b);
        logic a;
        host_u.wbyte(b, a);
        `CHK("ack", 1'b1, a)
    endtask
    // Block write of q from idx, then let the core catch up
    task automatic wr(input logic [7:0] idx);
        logic a;
        host_u.start();
        put(WR_ADDR);
        put(idx);
        put(8'(q.size()));
        foreach (q[i]) begin
            host_u.wbyte(q[i], a);
            `CHK("data ack", 1'b1, a)
        end
        host_u.stop();
        repeat (20) @(posedge clk);
    endtask
    // Block read from idx, compared with q
    task automatic rd(input logic [7:0] idx);
        logic [7:0] b;
        host_u.start();
        put(WR_ADDR);
        put(idx);
        host_u.start();
        put(RD_ADDR);
        foreach (q[i]) begin
            host_u.rbyte(i == q.size() - 1, b);
            `CHK("read byte", q[i], b)
        end
        host_u.stop();
    endtask
    // Outputs held until first power-good, then reset state
    task automatic t_power_up();
        `CHK("diff pre", 12'h000, ctrl.diff_run)
        `CHK("ref float", 1'b1, ctrl.ref_oe_n)
        pg <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("ctrl", ctrl_t'{12'hFFF, 7'h7F, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 8'h55, 4'h7, 3'h3, 1'b0}, ctrl)
    endtask
    // Full default read, then writes with reserved and read-only bytes
    task automatic t_regs();
        q = '{8'h0A, 8'hFF, 8'h9E, 8'h3F, 8'h55, 8'h03, 8'h07, 8'h03, 8'h69, 8'h0A, 8'hB4};
        rd(8'h00);
        q = '{8'hA5, 8'hFF, 8'hFF, 8'h1B, 8'hFE, 8'hFA, 8'h05};
        wr(8'h00);
        `CHK("ctrl", ctrl_t'{12'hFA5, 7'h7F, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2, 8'h1B, 4'hA, 3'h5, 1'b0}, ctrl)
        q = '{8'h00, 8'h03, 8'h00};
        wr(8'h07);
        q = '{8'h03, 8'h69, 8'h03, 8'hB4};
        rd(8'h07);
        q = '{8'h03, 8'h02, 8'h0A, 8'h05};
        rd(8'h04);
    endtask
    // Test mode: float first, then divided reference
    task automatic t_test();
        q = '{8'h43};
        wr(8'h06);
        `CHK("hiz", 1'b1, ctrl.outputs_hiz)
        `CHK("ref hiz", 1'b1, ctrl.ref_oe_n)
        q = '{8'hC3};
        wr(8'h06);
        `CHK("ref div", 1'b1, ctrl.ref_div_mode)
        `CHK("no hiz", 1'b0, ctrl.outputs_hiz)
    endtask
    // Power-down forces everything off, release restores
    task automatic t_power_down();
        @(posedge clk);
        pg <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("diff pd", 12'h000, ctrl.diff_run)
        `CHK("se pd", 7'h00, ctrl.se_run)
        `CHK("plls pd", 1'b1, ctrl.plls_stopped)
        pg <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("diff back", 12'hFA5, ctrl.diff_run)
        `CHK("data out", 1'b0, d_out)
    endtask
    // Main sequence: reset with link clock running, then scenarios
    initial begin
        rst_n = 1'b0;
        pg = 1'b1;
        fork
            host_u.idle(7);
            repeat (16) @(posedge clk);
        join
        rst_n <= 1'b1;
        host_u.idle(6);
        @(posedge clk);
        t_power_up();
        t_regs();
        t_test();
        t_power_down();
        tally_and_finish();
    end
    // Hang guard
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
